// ===== hw/lci_pkg.sv
/*
 * lci_pkg: shared constants, command codes, power states and the
 * packed carriers of the lpddr command/clock interface core.
 * assumes: one clock (the controller's true clock, 125 MHz).
 */
`default_nettype none

package lci_pkg;

	// ==========================================================
	// array geometry
	localparam int LCI_BANKS = 4;
	localparam int LCI_BANK_W = 2;
	localparam int LCI_ROW_W = 12;
	localparam int LCI_COL_W = 9;
	localparam int LCI_ADDR_W = 12;
	localparam int LCI_WORD_W = 16;
	localparam int LCI_AP_BIT = 10;

	// ==========================================================
	// burst length codes: words = 2 << code
	localparam logic [1:0] LCI_BL2 = 2'h0;
	localparam logic [1:0] LCI_BL4 = 2'h1;
	localparam logic [1:0] LCI_BL8 = 2'h2;
	localparam logic [1:0] LCI_BL16 = 2'h3;

	// read latency loads: cycles minus one
	localparam logic [1:0] LCI_CL2_LOAD = 2'h1;
	localparam logic [1:0] LCI_CL3_LOAD = 2'h2;

	// strobe per beat {fall half, rise half}: high on the rise half
	localparam logic [1:0] LCI_STROBE_BEAT = 2'h1;

	// ==========================================================
	// self refresh timing
	localparam real LCI_CLK_MHZ = 125.0;
	localparam real LCI_REFI_US = 15.6;
	// rounded down; small bias absorbs binary fraction error
	localparam int LCI_REFI_CYC = $rtoi(LCI_REFI_US * LCI_CLK_MHZ + 0.001);
	localparam int LCI_REFI_HOT_CYC = LCI_REFI_CYC / 2;
	localparam int LCI_REFI_W = 11;

	// ==========================================================
	// commands, {ras_n, cas_n, we_n} with chip select low
	typedef enum logic [2:0] {
		LCI_CMD_MRS = 3'b000,
		LCI_CMD_REF = 3'b001,
		LCI_CMD_PRE = 3'b010,
		LCI_CMD_ACT = 3'b011,
		LCI_CMD_WR = 3'b100,
		LCI_CMD_RD = 3'b101,
		LCI_CMD_BST = 3'b110,
		LCI_CMD_NOP = 3'b111
	} lci_cmd_t;

	// power states
	typedef enum logic [2:0] {
		LCI_PWR_RUN = 3'b000,
		LCI_PWR_PD_PRE = 3'b001,
		LCI_PWR_PD_ACT = 3'b010,
		LCI_PWR_SREF = 3'b011,
		LCI_PWR_DEEP = 3'b100
	} lci_pwr_t;

	// one data beat: two words, one per clock half
	typedef struct packed {
		logic [15:0] fall;
		logic [15:0] rise;
	} lci_beat_t;

	// write masks, bit 0 rise half, bit 1 fall half
	typedef struct packed {
		logic [1:0] high_byte_mask;
		logic [1:0] low_byte_mask;
	} lci_mask_t;

endpackage

`default_nettype wire

// ===== hw/lci_dram_core.sv
/*
 * lci_dram_core: device side of a four-bank 16-bit low-power ddr dram,
 * command decode, clock-gating power states, bursts and array.
 * assumes: clk_i is the true clock crossing; command and data pins are
 * launched by the controller on this clock; each beat carries both
 * clock halves as one packed pair; temp_hot, and cke at self refresh exit, may be asynchronous.
 */
// Function
// - register commands on rising true clock only
// - data moves on both clock halves
// - clock gate low stops clocks, buffers, drivers
// - gate low picks precharge/self/active power-down
// - gate synchronous, self refresh exit asynchronous
// - power-down disables all but clock inputs
// - chip select high masks every command
// - strobes plus chip select encode command
// - four independent banks
// - bank is 4096 rows by 512 columns
// - two-word prefetch per internal access
// - read latency two or three cycles
// - burst length 2, 4, 8 or 16
// - sequential or interleaved burst order
// - per-byte write mask blocks storage
// - optional auto close after each burst
// - tolerate clock stopped while idle
// - deep sleep and partial array self refresh
// - self refresh rate follows temperature
// - device drives strobe on reads only
// - strobe edge-aligned on reads, one per byte
// - masked byte dropped, mask per clock half
// - bank select, 12-bit row, 9-bit column, bit ten
`timescale 1ns/1ps
`default_nettype none

module lci_dram_core import lci_pkg::*; #(
	parameter int ROW_W = LCI_ROW_W,
	parameter int COL_W = LCI_COL_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// command pins
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [LCI_BANK_W-1:0] bank_select_i,
	input wire logic [LCI_ADDR_W-1:0] addr_i,
	// data pins
	input wire lci_beat_t dq_i,
	output var lci_beat_t dq_o,
	output logic dq_oe_o,
	input wire lci_mask_t write_byte_mask_i,
	input wire logic [1:0] low_byte_strobe_i,
	output logic [1:0] low_byte_strobe_o,
	output logic low_byte_strobe_oe_o,
	input wire logic [1:0] high_byte_strobe_i,
	output logic [1:0] high_byte_strobe_o,
	output logic high_byte_strobe_oe_o,
	// configuration
	input wire logic read_latency3_i,
	input wire logic [1:0] burst_len_i,
	input wire logic burst_interleave_i,
	input wire logic [LCI_BANKS-1:0] partial_array_refresh_i,
	input wire logic temp_hot_i,
	// status
	output var lci_pwr_t power_state_o,
	output logic [LCI_BANKS-1:0] open_banks_o,
	output logic self_refresh_tick_o,
	output logic [LCI_BANKS-1:0] refreshed_banks_o
);

	localparam int AW = LCI_BANK_W + ROW_W + COL_W;

	// ==========================================================
	// helpers
	// flat word address of bank, row, column
	function automatic logic [AW-1:0] word_addr(input logic [LCI_BANK_W-1:0] b,
		input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c);
		word_addr = {b, r, c};
	endfunction

	// column of word idx in a burst; the wrap stays inside the burst block
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
		input logic [3:0] idx, input logic [1:0] bl, input logic ilv);
		logic [COL_W-1:0] msk;
		logic [COL_W-1:0] off;
		msk = COL_W'((5'h2 << bl) - 5'h1);
		off = ilv ? (start ^ COL_W'(idx)) : (start + COL_W'(idx));
		burst_col = (start & ~msk) | (off & msk);
	endfunction

	// ==========================================================
	// state
	logic cke_meta, cke_sync; // self refresh exit synchroniser
	logic temp_meta, temp_sync; // temperature synchroniser
	logic [LCI_BANKS-1:0] open_q; // row open per bank
	logic [ROW_W-1:0] open_row [LCI_BANKS]; // open row per bank
	logic [LCI_WORD_W-1:0] mem [0:(1<<AW)-1]; // the array, no reset
	logic [LCI_REFI_W-1:0] sr_cnt; // internal refresh timer
	// read engine
	logic rd_pend;
	logic [1:0] rd_lat;
	logic [2:0] rd_beat, rd_last;
	logic [LCI_BANK_W-1:0] rd_bank;
	logic [ROW_W-1:0] rd_row;
	logic [COL_W-1:0] rd_col;
	logic [1:0] rd_bl;
	logic rd_ilv, rd_ap;
	// write engine
	logic wr_act;
	logic [2:0] wr_beat, wr_last;
	logic [LCI_BANK_W-1:0] wr_bank;
	logic [ROW_W-1:0] wr_row;
	logic [COL_W-1:0] wr_col;
	logic [1:0] wr_bl;
	logic wr_ilv, wr_ap;
	logic strobe_drv; // read strobe drive

	// ==========================================================
	// command decode
	lci_cmd_t cmd;
	logic run, take, bank_open, all_idle;
	logic rd_go, wr_go, emit, rd_close, wr_close;
	assign cmd = lci_cmd_t'({ras_n_i, cas_n_i, we_n_i});
	// commands only reach the decoder with clocks running
	assign run = (power_state_o == LCI_PWR_RUN) && cke_i;
	assign take = run && !cs_n_i;
	assign bank_open = open_q[bank_select_i];
	assign all_idle = !(|open_q);
	// reads and writes to a closed bank start no burst, yet still cut off a burst of the other kind
	assign rd_go = take && (cmd == LCI_CMD_RD) && bank_open;
	assign wr_go = take && (cmd == LCI_CMD_WR) && bank_open;
	assign emit = rd_pend && (rd_lat == 2'h0) && (power_state_o == LCI_PWR_RUN);
	assign rd_close = emit && (rd_beat == rd_last) && rd_ap;
	assign wr_close = wr_act && (wr_beat == wr_last) && wr_ap;
	assign open_banks_o = open_q;

	// ==========================================================
	// synchronisers for asynchronous levels
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cke_meta <= 1'b0;
			cke_sync <= 1'b0;
			temp_meta <= 1'b0;
			temp_sync <= 1'b0;
		end else begin
			cke_meta <= cke_i;
			// held low outside self refresh: the high that the gate still carried
			// just before entry must not end the state on the next edge
			cke_sync <= cke_meta && (power_state_o == LCI_PWR_SREF);
			temp_meta <= temp_hot_i;
			temp_sync <= temp_meta;
		end
	end

	// ==========================================================
	// power states; each state simply holds while the clock is stopped
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			power_state_o <= LCI_PWR_RUN;
		end else begin
			case (power_state_o)
				LCI_PWR_RUN: begin
					if (!cke_i) begin
						if (!cs_n_i && cmd == LCI_CMD_REF && all_idle) begin
							power_state_o <= LCI_PWR_SREF;
						end else if (!cs_n_i && cmd == LCI_CMD_BST && all_idle) begin
							power_state_o <= LCI_PWR_DEEP;
						end else if (all_idle) begin
							power_state_o <= LCI_PWR_PD_PRE;
						end else begin
							power_state_o <= LCI_PWR_PD_ACT;
						end
					end
				end
				LCI_PWR_PD_PRE, LCI_PWR_PD_ACT, LCI_PWR_DEEP: begin
					// plain power-down exit: gate sampled on the clock
					if (cke_i) begin
						power_state_o <= LCI_PWR_RUN;
					end
				end
				LCI_PWR_SREF: begin
					// exit seen without any command timing
					if (cke_sync) begin
						power_state_o <= LCI_PWR_RUN;
					end
				end
				default: begin
					power_state_o <= LCI_PWR_RUN;
				end
			endcase
		end
	end

	// ==========================================================
	// self refresh timer; hot die halves the interval
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sr_cnt <= LCI_REFI_W'(LCI_REFI_CYC - 1);
			self_refresh_tick_o <= 1'b0;
			refreshed_banks_o <= '0;
		end else if (power_state_o != LCI_PWR_SREF) begin
			sr_cnt <= LCI_REFI_W'(LCI_REFI_CYC - 1);
			self_refresh_tick_o <= 1'b0;
		end else if (sr_cnt == '0) begin
			// only the selected part of the array is kept
			sr_cnt <= temp_sync ? LCI_REFI_W'(LCI_REFI_HOT_CYC - 1)
				: LCI_REFI_W'(LCI_REFI_CYC - 1);
			self_refresh_tick_o <= 1'b1;
			refreshed_banks_o <= partial_array_refresh_i;
		end else begin
			sr_cnt <= sr_cnt - 1'b1;
			self_refresh_tick_o <= 1'b0;
		end
	end

	// ==========================================================
	// bank rows: open, close, auto close
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			open_q <= '0;
			for (int b = 0; b < LCI_BANKS; b++) begin
				open_row[b] <= '0;
			end
		end else begin
			for (int b = 0; b < LCI_BANKS; b++) begin
				if (take && cmd == LCI_CMD_ACT && bank_select_i == b) begin
					open_q[b] <= 1'b1;
					open_row[b] <= addr_i[ROW_W-1:0];
				end else if (take && cmd == LCI_CMD_PRE
					&& (addr_i[LCI_AP_BIT] || bank_select_i == b)) begin
					open_q[b] <= 1'b0;
				end else if ((rd_close && rd_bank == b) || (wr_close && wr_bank == b)) begin
					open_q[b] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// read engine: latency count, then one beat per cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_pend <= 1'b0;
			rd_lat <= 2'h0;
			rd_beat <= 3'h0;
			rd_last <= 3'h0;
			rd_bank <= '0;
			rd_row <= '0;
			rd_col <= '0;
			rd_bl <= LCI_BL2;
			rd_ilv <= 1'b0;
			rd_ap <= 1'b0;
		end else if (rd_go) begin
			rd_pend <= 1'b1;
			rd_lat <= read_latency3_i ? LCI_CL3_LOAD : LCI_CL2_LOAD;
			rd_beat <= 3'h0;
			rd_last <= 3'((4'h1 << burst_len_i) - 4'h1);
			rd_bank <= bank_select_i;
			rd_row <= open_row[bank_select_i];
			rd_col <= addr_i[COL_W-1:0];
			rd_bl <= burst_len_i;
			rd_ilv <= burst_interleave_i;
			rd_ap <= addr_i[LCI_AP_BIT];
		end else if (power_state_o != LCI_PWR_RUN
			|| (take && (cmd == LCI_CMD_BST || cmd == LCI_CMD_WR))) begin
			// terminate, write, or the clocks stopped under a read
			rd_pend <= 1'b0;
		end else if (rd_pend && rd_lat != 2'h0) begin
			rd_lat <= rd_lat - 1'b1;
		end else if (emit) begin
			if (rd_beat == rd_last) begin
				rd_pend <= 1'b0;
			end else begin
				rd_beat <= rd_beat + 1'b1;
			end
		end
	end

	// ==========================================================
	// read data and strobe; drivers off outside bursts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			strobe_drv <= 1'b0;
		end else begin
			dq_oe_o <= emit;
			strobe_drv <= emit;
			if (emit) begin
				// one double-width fetch split over the two halves
				dq_o.rise <= mem[word_addr(rd_bank, rd_row,
					burst_col(rd_col, {rd_beat, 1'b0}, rd_bl, rd_ilv))];
				dq_o.fall <= mem[word_addr(rd_bank, rd_row,
					burst_col(rd_col, {rd_beat, 1'b1}, rd_bl, rd_ilv))];
			end
		end
	end
	// edge-aligned: strobe high with the rise word, low with the fall word
	assign low_byte_strobe_o = strobe_drv ? LCI_STROBE_BEAT : 2'h0;
	assign high_byte_strobe_o = strobe_drv ? LCI_STROBE_BEAT : 2'h0;
	assign low_byte_strobe_oe_o = strobe_drv;
	assign high_byte_strobe_oe_o = strobe_drv;

	// ==========================================================
	// write engine: data one cycle after the command
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_act <= 1'b0;
			wr_beat <= 3'h0;
			wr_last <= 3'h0;
			wr_bank <= '0;
			wr_row <= '0;
			wr_col <= '0;
			wr_bl <= LCI_BL2;
			wr_ilv <= 1'b0;
			wr_ap <= 1'b0;
		end else if (wr_go) begin
			wr_act <= 1'b1;
			wr_beat <= 3'h0;
			wr_last <= 3'((4'h1 << burst_len_i) - 4'h1);
			wr_bank <= bank_select_i;
			wr_row <= open_row[bank_select_i];
			wr_col <= addr_i[COL_W-1:0];
			wr_bl <= burst_len_i;
			wr_ilv <= burst_interleave_i;
			wr_ap <= addr_i[LCI_AP_BIT];
		end else if (power_state_o != LCI_PWR_RUN
			|| (take && (cmd == LCI_CMD_BST || cmd == LCI_CMD_RD))) begin
			wr_act <= 1'b0;
		end else if (wr_act) begin
			if (wr_beat == wr_last) begin
				wr_act <= 1'b0;
			end else begin
				wr_beat <= wr_beat + 1'b1;
			end
		end
	end

	// ==========================================================
	// array write; a lane needs its strobe beat and a clear mask
	logic [AW-1:0] wa [2];
	logic [1:0] lane_en [2];
	always_comb begin
		for (int h = 0; h < 2; h++) begin
			wa[h] = word_addr(wr_bank, wr_row,
				burst_col(wr_col, {wr_beat, h[0]}, wr_bl, wr_ilv));
			lane_en[h][0] = !write_byte_mask_i.low_byte_mask[h]
				&& low_byte_strobe_i == LCI_STROBE_BEAT;
			lane_en[h][1] = !write_byte_mask_i.high_byte_mask[h]
				&& high_byte_strobe_i == LCI_STROBE_BEAT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_act && power_state_o == LCI_PWR_RUN) begin
			for (int l = 0; l < 2; l++) begin
				if (lane_en[0][l]) begin
					mem[wa[0]][l*8 +: 8] <= dq_i.rise[l*8 +: 8];
				end
				if (lane_en[1][l]) begin
					mem[wa[1]][l*8 +: 8] <= dq_i.fall[l*8 +: 8];
				end
			end
		end
	end

	// ==========================================================
	// checks
	a_cs_masks_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
		(cs_n_i && !rd_pend && !wr_act) |=> $stable(open_banks_o))
		else $error("bank state changed while deselected");
	a_read_lat_two: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_go && !read_latency3_i && !rd_pend && !dq_oe_o)
		|-> ##2 !dq_oe_o ##1 dq_oe_o)
		else $error("latency two data misplaced");
	a_read_lat_three: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_go && read_latency3_i && !rd_pend && !dq_oe_o)
		|-> ##2 !dq_oe_o ##1 !dq_oe_o ##1 dq_oe_o)
		else $error("latency three data misplaced");
	a_burst_four_len: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_go && !read_latency3_i && burst_len_i == LCI_BL4 && !rd_pend && !dq_oe_o)
		##1 (cs_n_i && cke_i)[*3] |-> dq_oe_o ##1 dq_oe_o ##1 !dq_oe_o)
		else $error("burst of four not two beats");
	a_read_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
		dq_oe_o |-> (low_byte_strobe_oe_o && high_byte_strobe_o == LCI_STROBE_BEAT))
		else $error("read strobe not driven with data");
	a_write_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_go && !rd_pend && !dq_oe_o) |=> !low_byte_strobe_oe_o)
		else $error("strobe driven during write");
	a_pd_drivers: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_state_o != LCI_PWR_RUN) |=> !dq_oe_o && !high_byte_strobe_oe_o)
		else $error("drivers on in power-down");
	a_pd_entry_pre: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_state_o == LCI_PWR_RUN && !cke_i && cs_n_i && all_idle)
		|=> power_state_o == LCI_PWR_PD_PRE)
		else $error("precharge power-down not entered");
	a_pd_entry_act: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_state_o == LCI_PWR_RUN && !cke_i && !all_idle && !rd_close && !wr_close)
		|=> power_state_o == LCI_PWR_PD_ACT)
		else $error("active power-down not entered");
	a_sref_exit: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_state_o == LCI_PWR_SREF && !cke_i) ##1 cke_i[*3]
		|=> power_state_o == LCI_PWR_RUN)
		else $error("self refresh exit missed");

endmodule

`default_nettype wire

// ===== dv/lci_ctrl_model.sv
/*
 * lci_ctrl_model: behavioural memory controller that drives the command,
 * clock-gate and write-data pins of the dram core.
 * assumes: the bench calls wbeat and wrel only at falling clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module lci_ctrl_model import lci_pkg::*; (
	// clock
	input wire logic clk_i,
	// command pins, cmd_o is {cs_n, ras_n, cas_n, we_n}
	output logic cke_o,
	output logic [3:0] cmd_o,
	output logic [1:0] bank_o,
	output logic [11:0] addr_o,
	// write data pins
	output var lci_beat_t dq_o,
	output var lci_mask_t mask_o,
	output logic [1:0] strobe_o
);
	// ==========================================================
	// idle levels: deselected, strobes parked off the 01 write pattern
	initial begin
		cke_o = 1'b1;
		cmd_o = 4'hf;
		bank_o = 2'h0;
		addr_o = 12'h000;
		dq_o = '0;
		mask_o = '0;
		strobe_o = 2'h2;
	end

	// ==========================================================
	// one command on one rising edge, then deselect straight away
	task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a,
		input logic ck);
		@(negedge clk_i);
		cmd_o <= c;
		bank_o <= ba;
		addr_o <= a;
		cke_o <= ck;
		@(negedge clk_i);
		cmd_o <= 4'hf;
		// released lines show the inverse, never the last value
		bank_o <= ~ba;
		addr_o <= ~a;
	endtask

	// one write beat: both halves, strobe pattern 01 on each lane
	task automatic wbeat(input lci_beat_t d, input lci_mask_t m);
		dq_o <= d;
		mask_o <= m;
		strobe_o <= 2'h1;
		@(negedge clk_i);
	endtask

	// release the data lanes after the last beat
	task automatic wrel();
		dq_o <= ~dq_o;
		mask_o <= ~mask_o;
		strobe_o <= 2'h2;
	endtask

	// raise the clock gate and let one edge see it
	task automatic wake();
		@(negedge clk_i);
		cke_o <= 1'b1;
		@(negedge clk_i);
	endtask

	// one refresh per interval keeps every row inside its retention time
	task automatic refresh();
		cmd({1'b0, LCI_CMD_REF}, 2'h0, 12'h000, 1'b1);
	endtask
endmodule

`default_nettype wire

// ===== dv/tb.sv
/*
 * tb: self-checking bench of the dram core, array shrunk to 16 rows by 32
 * columns, with the controller model on the far side.
 * assumes: 125 MHz clock, reset held 4 cycles, inputs moved at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module tb import lci_pkg::*;;
	// ==========================================================
	// clock, reset and pins
	logic clk = 1'b0;
	logic clk_run = 1'b1; // low stops the clock while idle
	logic rst = 1'b1;
	logic cl3, ilv, hot, cke;
	logic [1:0] bl, ba, wstb, lso, hso;
	logic [3:0] pmask, cmd, obank, rbanks;
	logic [11:0] addr;
	logic rdq_oe, lsoe, hsoe, tick;
	lci_beat_t wdq, rdq, dq_w;
	lci_mask_t wmask;
	lci_pwr_t pst;
	logic [15:0] m [32]; // expected array contents of bank 0, row 3
	int n_mismatch, n_tests, cycles;

	always #4 clk = clk_run ? ~clk : clk;

	// wire levels of the two-way pins
	assign dq_w = rdq_oe ? rdq : wdq;
	wire logic [1:0] stb_l = lsoe ? lso : wstb;
	wire logic [1:0] stb_h = hsoe ? hso : wstb;

	lci_ctrl_model ctl (.clk_i(clk), .cke_o(cke), .cmd_o(cmd), .bank_o(ba), .addr_o(addr),
		.dq_o(wdq), .mask_o(wmask), .strobe_o(wstb));

	lci_dram_core #(.ROW_W(4), .COL_W(5)) dut (.clk_i(clk), .rst_i(rst), .cke_i(cke),
		.cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
		.bank_select_i(ba), .addr_i(addr), .dq_i(dq_w), .dq_o(rdq), .dq_oe_o(rdq_oe),
		.write_byte_mask_i(wmask), .low_byte_strobe_i(stb_l), .low_byte_strobe_o(lso),
		.low_byte_strobe_oe_o(lsoe), .high_byte_strobe_i(stb_h), .high_byte_strobe_o(hso),
		.high_byte_strobe_oe_o(hsoe), .read_latency3_i(cl3), .burst_len_i(bl),
		.burst_interleave_i(ilv), .partial_array_refresh_i(pmask), .temp_hot_i(hot),
		.power_state_o(pst), .open_banks_o(obank), .self_refresh_tick_o(tick),
		.refreshed_banks_o(rbanks));

	// ==========================================================
	// reporting
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard: the whole run needs about 5000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ==========================================================
	// column of word i of a burst inside its aligned block
	function automatic logic [4:0] bcol(input logic [4:0] s, input int i, input logic [1:0] b,
		input logic il);
		logic [4:0] k;
		k = 5'((2 << b) - 1);
		return (s & ~k) | ((il ? (s ^ 5'(i)) : (s + 5'(i))) & k);
	endfunction

	// sequential write burst from an aligned column, mask held on all beats
	task automatic wr(input logic [4:0] col, input logic [1:0] b, input logic [15:0] base,
		input lci_mask_t mk);
		logic [15:0] w;
		bl <= b;
		ilv <= 1'b0;
		ctl.cmd({1'b0, LCI_CMD_WR}, 2'h0, {7'h00, col}, 1'b1);
		for (int k = 0; k < (2 << b); k += 2) begin
			ctl.wbeat({base + 16'(k + 1), base + 16'(k)}, mk);
			for (int h = 0; h < 2; h++) begin
				w = base + 16'(k + h);
				if (!mk.low_byte_mask[h]) m[col + 5'(k + h)][7:0] = w[7:0];
				if (!mk.high_byte_mask[h]) m[col + 5'(k + h)][15:8] = w[15:8];
			end
		end
		ctl.wrel();
	endtask

	// read burst: quiet until the latency runs out, then one beat a cycle
	task automatic rd(input logic [4:0] col, input logic c3, input logic [1:0] b,
		input logic il, input logic ap);
		cl3 <= c3;
		bl <= b;
		ilv <= il;
		ctl.cmd({1'b0, LCI_CMD_RD}, 2'h0, {1'b0, ap, 5'h00, col}, 1'b1);
		repeat (c3 ? 2 : 1) @(negedge clk);
		chk(32'(rdq_oe), 32'h0);
		for (int k = 0; k < (2 << b); k += 2) begin
			@(negedge clk);
			chk(32'({lsoe, hsoe, rdq_oe, lso, hso}), 32'h75);
			chk(rdq, {m[bcol(col, k + 1, b, il)], m[bcol(col, k, b, il)]});
		end
		@(negedge clk);
		chk(32'({lsoe, hsoe, rdq_oe}), 32'h0);
	endtask

	// ==========================================================
	// writes with masks, then reads over every length, latency and order
	task automatic t_rw();
		ctl.cmd({1'b0, LCI_CMD_ACT}, 2'h0, 12'h003, 1'b1);
		wr(5'h00, LCI_BL16, 16'ha0a0, lci_mask_t'(4'h0));
		wr(5'h06, LCI_BL2, 16'h5555, lci_mask_t'(4'h9));
		rd(5'h04, 1'b0, LCI_BL4, 1'b0, 1'b0);
		rd(5'h05, 1'b1, LCI_BL4, 1'b1, 1'b0);
		rd(5'h03, 1'b0, LCI_BL8, 1'b1, 1'b0);
		rd(5'h09, 1'b1, LCI_BL16, 1'b0, 1'b0);
		// a terminate two cycles after the read leaves a single beat
		bl <= LCI_BL16;
		cl3 <= 1'b0;
		ctl.cmd({1'b0, LCI_CMD_RD}, 2'h0, 12'h000, 1'b1);
		ctl.cmd({1'b0, LCI_CMD_BST}, 2'h0, 12'h000, 1'b1);
		chk(32'(rdq_oe), 32'h1);
		chk(rdq, {m[1], m[0]});
		@(negedge clk);
		chk(32'(rdq_oe), 32'h0);
		rd(5'h06, 1'b1, LCI_BL2, 1'b0, 1'b1);
		@(negedge clk);
		chk(32'(obank), 32'h0);
	endtask

	// cycles to the next self refresh tick
	task automatic gap(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 3000);
	endtask

	// deselect, power-down kinds, self refresh, deep sleep, clock stop
	task automatic t_power();
		int n;
		ctl.cmd({1'b0, LCI_CMD_ACT}, 2'h1, 12'h002, 1'b1);
		ctl.cmd({1'b1, LCI_CMD_ACT}, 2'h2, 12'h002, 1'b1);
		ctl.cmd({1'b0, LCI_CMD_ACT}, 2'h3, 12'h001, 1'b1);
		@(negedge clk);
		chk(32'(obank), 32'ha);
		ctl.cmd({1'b0, LCI_CMD_PRE}, 2'h3, 12'h000, 1'b1);
		ctl.cmd({1'b0, LCI_CMD_NOP}, 2'h0, 12'h000, 1'b0);
		@(negedge clk);
		chk(32'({pst, obank, rdq_oe}), 32'({LCI_PWR_PD_ACT, 4'h2, 1'b0}));
		ctl.wake();
		chk(32'(pst), 32'(LCI_PWR_RUN));
		ctl.cmd({1'b0, LCI_CMD_PRE}, 2'h0, 12'h400, 1'b1);
		ctl.cmd({1'b0, LCI_CMD_NOP}, 2'h0, 12'h000, 1'b0);
		ctl.cmd({1'b0, LCI_CMD_ACT}, 2'h2, 12'h001, 1'b0);
		chk(32'({pst, obank}), 32'({LCI_PWR_PD_PRE, 4'h0}));
		ctl.wake();
		pmask <= 4'h5;
		ctl.cmd({1'b0, LCI_CMD_REF}, 2'h0, 12'h000, 1'b0);
		chk(32'(pst), 32'(LCI_PWR_SREF));
		gap(n);
		chk(32'(n > 1940 && n < 1960 && rbanks === 4'h5), 32'h1);
		hot <= 1'b1;
		gap(n);
		gap(n);
		chk(32'(n > 965 && n < 985), 32'h1);
		hot <= 1'b0;
		ctl.wake();
		repeat (3) @(negedge clk);
		chk(32'(pst), 32'(LCI_PWR_RUN));
		ctl.cmd({1'b0, LCI_CMD_BST}, 2'h0, 12'h000, 1'b0);
		chk(32'(pst), 32'(LCI_PWR_DEEP));
		ctl.wake();
		chk(32'(pst), 32'(LCI_PWR_RUN));
		// stop with the clock low, restart off the toggle grid
		clk_run = 1'b0;
		#202;
		clk_run = 1'b1;
		ctl.cmd({1'b0, LCI_CMD_ACT}, 2'h2, 12'h001, 1'b1);
		ctl.refresh();
		chk(32'({pst, obank}), 32'({LCI_PWR_RUN, 4'h4}));
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_mismatch = 0;
		n_tests = 0;
		cycles = 0;
		cl3 = 1'b0;
		bl = 2'h0;
		ilv = 1'b0;
		pmask = 4'hf;
		hot = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst <= 1'b0;
		t_rw();
		t_power();
		conclude();
	end
endmodule

`default_nettype wire
